// ---- verilog/rtcacc_map.svh ----
`ifndef RTCACC_MAP_SVH
`define RTCACC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTCACC_HUNDREDTHS_COUNT 8'h00
`define RTCACC_SECONDS_COUNT 8'h01
`define RTCACC_MINUTES_COUNT 8'h02
`define RTCACC_HOURS_COUNT 8'h03
`define RTCACC_DAY_OF_MONTH_COUNT 8'h04
`define RTCACC_DAY_OF_WEEK_COUNT 8'h05
`define RTCACC_MONTH_COUNT 8'h06
`define RTCACC_YEAR_COUNT 8'h07
`define RTCACC_FIRST_ALARM_SECOND_MATCH 8'h08
`define RTCACC_FIRST_ALARM_MINUTE_MATCH 8'h09
`define RTCACC_FIRST_ALARM_HOUR_MATCH 8'h0a
`define RTCACC_FIRST_ALARM_DAY_MATCH 8'h0b
`define RTCACC_FIRST_ALARM_MONTH_MATCH 8'h0c
`define RTCACC_SECOND_ALARM_MINUTE_MATCH 8'h0d
`define RTCACC_SECOND_ALARM_HOUR_MATCH 8'h0e
`define RTCACC_SECOND_ALARM_DOW_MATCH 8'h0f
`define RTCACC_ALARM_FIELD_ENABLES 8'h10
`define RTCACC_FUNCTION_CONTROL 8'h28
`define RTCACC_PTR_FIRST 8'h00
`define RTCACC_PTR_LAST 8'h2f
`define RTCACC_ALARM_COUNT 9

// ----------------------------------------------------------------
// Field positions in the function control register
// ----------------------------------------------------------------
`define RTCACC_VIEW_BIT 4
`define RTCACC_TWELVE_BIT 5
`define RTCACC_FUNC_MASK 8'h30

// ----------------------------------------------------------------
// Alarm enable bit positions
// ----------------------------------------------------------------
`define RTCACC_EN_A1_SEC 0
`define RTCACC_EN_A1_MIN 1
`define RTCACC_EN_A1_HOUR 2
`define RTCACC_EN_A1_DAY 3
`define RTCACC_EN_A1_MON 4
`define RTCACC_EN_A2_MIN 5
`define RTCACC_EN_A2_HOUR 6
`define RTCACC_EN_A2_DOW 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTCACC_RST_DAY 8'h01
`define RTCACC_RST_MONTH 8'h01

// ----------------------------------------------------------------
// Timing and counting limits
// ----------------------------------------------------------------
`define RTCACC_OSC_HZ 32768
`define RTCACC_TICK_HZ 100
`define RTCACC_BUS_MAX_KBPS 400
`define RTCACC_HUND_LAST 8'h99
`define RTCACC_MINSEC_LAST 8'h59
`define RTCACC_HOUR24_LAST 8'h23
`define RTCACC_HOUR12_LAST 8'h12
`define RTCACC_DOW_LAST 8'h06
`define RTCACC_MONTH_LAST 8'h12
`define RTCACC_YEAR_LAST 8'h99

`endif

// ---- verilog/rtcacc_pkg.sv ----
`include "rtcacc_map.svh"

package rtcacc_pkg;

	// ----------------------------------------------------------------
	// Byte level request from the serial engine
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ptr_load;
		logic wr;
		logic rd;
		logic [7:0] data;
	} rtcacc_req_s;

	typedef enum logic [1:0] {
		FRZ_RUN = 2'b01,
		FRZ_HOLD = 2'b10
	} rtcacc_frz_e;

	// ----------------------------------------------------------------
	// State of the access block apart from the alarm and enable storage
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ptr;
		logic [7:0] rdata;
		logic rd_mem;
		logic [7:0] hund;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] mon;
		logic [7:0] year;
		logic [23:0] ehours;
		logic [7:0] func;
		logic [15:0] acc;
		logic [3:0] pend;
		logic alm1;
		logic alm2;
		rtcacc_frz_e frz;
	} rtcacc_state_s;

endpackage

// ---- verilog/rtcacc_regmem.sv ----
`timescale 1ns/10ps

module rtcacc_regmem
	import rtcacc_pkg::*;
#(
	parameter int DEPTH = `RTCACC_ALARM_COUNT,
	parameter int DW = 8,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [DW-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o,
	output logic [DEPTH-1:0][DW-1:0] cells_o
);

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] cells;
		logic [DW-1:0] rd;
	} rtcacc_mem_s;

	rtcacc_mem_s q;
	rtcacc_mem_s n;

	// ----------------------------------------------------------------
	// Storage with registered read port
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		if (wr_en_i && (32'(wr_addr_i) < DEPTH)) begin
			n.cells[wr_addr_i] = wr_data_i;
		end
		if (rd_en_i) begin
			n.rd = (32'(rd_addr_i) < DEPTH) ? q.cells[rd_addr_i] : '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign rd_data_o = q.rd;
	assign cells_o = q.cells;

endmodule // rtcacc_regmem

// ---- verilog/rtcacc_top.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// - Pointer steps by one after every data byte read or written.
// - Stepping past the last location returns the pointer to the first.
// - Every location is one byte wide, even where bits have no storage.
// - Time, calendar and alarm fields are kept as packed BCD digits.
// - A read of a time register freezes counting until the transfer ends.
// - A mode bit picks calendar view or elapsed-time view of time locations.
// - Serial access up to 400 kbit/s; host must stay at or below it.
// - Hours run 1..12 with afternoon bit in 12-hour mode, else 0..23.
// - Counters advance from a tick divided down from the 32.768 kHz oscillator.

module rtcacc_top
	import rtcacc_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic osc_tick_i,
	input wire logic xfer_active_i,
	input rtcacc_req_s req_i,
	output logic [7:0] rd_data_o,
	output logic [7:0] ptr_o,
	output logic frozen_o,
	output logic clock_view_select_o,
	output logic alarm1_match_o,
	output logic alarm2_match_o
);

	rtcacc_state_s q;
	rtcacc_state_s n;

	logic [`RTCACC_ALARM_COUNT-1:0][7:0] alm;
	logic [7:0] mem_rd;
	logic mem_wr;
	logic mem_rd_en;
	logic [3:0] mem_addr;
	logic [7:0] wmask;
	logic [7:0] wval;
	logic [7:0] rval;
	logic [16:0] acc_sum;
	logic [8:0] s;
	logic [4:0] h12;
	logic tick;
	logic advance;
	logic day_c;
	logic view;
	logic twelve;
	logic [7:0] en;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Step a BCD byte; at or past the last value it wraps to first and
	// reports a carry, so an out-of-range value written by software recovers.
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		logic [8:0] r;
		r = 9'h000;
		if (v >= last) begin
			r = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	function automatic logic [23:0] bcd6_inc(input logic [23:0] v);
		logic [23:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (c) begin
				if (r[i*4+:4] == 4'h9) begin
					r[i*4+:4] = 4'h0;
				end else begin
					r[i*4+:4] = r[i*4+:4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Two-digit years only, so every year divisible by four is a leap year
	function automatic logic is_leap(input logic [7:0] y);
		logic r;
		r = 1'b0;
		if (y[4]) begin
			r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end else begin
			r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end
		return r;
	endfunction

	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		logic [7:0] r;
		r = 8'h31;
		case (m)
			8'h02: begin
				r = is_leap(y) ? 8'h29 : 8'h28;
			end
			8'h04, 8'h06, 8'h09, 8'h11: begin
				r = 8'h30;
			end
			default: begin
				r = 8'h31;
			end
		endcase
		return r;
	endfunction

	function automatic logic is_alarm(input logic [7:0] a);
		return (a >= `RTCACC_FIRST_ALARM_SECOND_MATCH) && (a <= `RTCACC_ALARM_FIELD_ENABLES);
	endfunction

	// Implemented bits per location; shared by read and write paths
	function automatic logic [7:0] field_mask(input logic [7:0] a, input logic sw);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`RTCACC_HUNDREDTHS_COUNT, `RTCACC_SECONDS_COUNT, `RTCACC_MINUTES_COUNT: begin
				r = 8'hff;
			end
			`RTCACC_HOURS_COUNT, `RTCACC_DAY_OF_MONTH_COUNT: begin
				r = sw ? 8'hff : 8'h3f;
			end
			`RTCACC_DAY_OF_WEEK_COUNT: begin
				r = sw ? 8'hff : 8'h07;
			end
			`RTCACC_MONTH_COUNT: begin
				r = sw ? 8'h00 : 8'h1f;
			end
			`RTCACC_YEAR_COUNT: begin
				r = sw ? 8'h00 : 8'hff;
			end
			`RTCACC_FIRST_ALARM_SECOND_MATCH, `RTCACC_FIRST_ALARM_MINUTE_MATCH,
			`RTCACC_SECOND_ALARM_MINUTE_MATCH: begin
				r = 8'h7f;
			end
			`RTCACC_FIRST_ALARM_HOUR_MATCH, `RTCACC_FIRST_ALARM_DAY_MATCH,
			`RTCACC_SECOND_ALARM_HOUR_MATCH: begin
				r = 8'h3f;
			end
			`RTCACC_FIRST_ALARM_MONTH_MATCH: begin
				r = 8'h1f;
			end
			`RTCACC_SECOND_ALARM_DOW_MATCH: begin
				r = 8'h07;
			end
			`RTCACC_ALARM_FIELD_ENABLES: begin
				r = 8'hff;
			end
			`RTCACC_FUNCTION_CONTROL: begin
				r = `RTCACC_FUNC_MASK;
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Alarm and enable storage
	// ----------------------------------------------------------------
	assign mem_addr = 4'(q.ptr - `RTCACC_FIRST_ALARM_SECOND_MATCH);
	assign wmask = field_mask(q.ptr, view);
	assign wval = req_i.data & wmask;
	assign mem_wr = req_i.wr && !req_i.ptr_load && is_alarm(q.ptr);
	assign mem_rd_en = req_i.rd && !req_i.ptr_load && is_alarm(q.ptr);

	rtcacc_regmem #(
		.DEPTH(`RTCACC_ALARM_COUNT),
		.DW(8),
		.AW(4)
	) u_alarm_mem (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.wr_en_i(mem_wr),
		.wr_addr_i(mem_addr),
		.wr_data_i(wval),
		.rd_en_i(mem_rd_en),
		.rd_addr_i(mem_addr),
		.rd_data_o(mem_rd),
		.cells_o(alm)
	);

	assign view = q.func[`RTCACC_VIEW_BIT];
	assign twelve = q.func[`RTCACC_TWELVE_BIT];
	assign en = alm[`RTCACC_ALARM_COUNT-1];

	// ----------------------------------------------------------------
	// Read value of the addressed location
	// ----------------------------------------------------------------
	always_comb begin
		rval = 8'h00;
		case (q.ptr)
			`RTCACC_HUNDREDTHS_COUNT: rval = q.hund;
			`RTCACC_SECONDS_COUNT: rval = q.sec;
			`RTCACC_MINUTES_COUNT: rval = q.min;
			`RTCACC_HOURS_COUNT: rval = view ? q.ehours[7:0] : q.hour;
			`RTCACC_DAY_OF_MONTH_COUNT: rval = view ? q.ehours[15:8] : q.day;
			`RTCACC_DAY_OF_WEEK_COUNT: rval = view ? q.ehours[23:16] : q.wday;
			`RTCACC_MONTH_COUNT: rval = q.mon;
			`RTCACC_YEAR_COUNT: rval = q.year;
			`RTCACC_FUNCTION_CONTROL: rval = q.func;
			default: rval = 8'h00;
		endcase
		rval = rval & wmask;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		tick = 1'b0;
		s = 9'h000;
		h12 = 5'h00;
		day_c = 1'b0;
		acc_sum = {1'b0, q.acc};

		// Fractional divider: 100 ticks from 32768 oscillator edges, no drift
		if (osc_tick_i) begin
			acc_sum = {1'b0, q.acc} + 17'(`RTCACC_TICK_HZ);
			if (acc_sum >= 17'(`RTCACC_OSC_HZ)) begin
				acc_sum = acc_sum - 17'(`RTCACC_OSC_HZ);
				tick = 1'b1;
			end
			n.acc = acc_sum[15:0];
		end

		// Up to 15 ticks seen while frozen are banked and replayed afterwards
		advance = (q.frz == FRZ_RUN) && (tick || (q.pend != 4'h0));
		if (tick && !advance && (q.pend != 4'hf)) begin
			n.pend = q.pend + 4'h1;
		end else if (!tick && advance) begin
			n.pend = q.pend - 4'h1;
		end

		case (q.frz)
			FRZ_RUN: begin
				if (req_i.rd && !req_i.ptr_load && (q.ptr <= `RTCACC_YEAR_COUNT)) begin
					n.frz = FRZ_HOLD;
				end
			end
			FRZ_HOLD: begin
				if (!xfer_active_i) begin
					n.frz = FRZ_RUN;
				end
			end
			default: begin
				n.frz = FRZ_RUN;
			end
		endcase

		// BCD carry chain
		if (advance) begin
			s = bcd_step(q.hund, `RTCACC_HUND_LAST, 8'h00);
			n.hund = s[7:0];
			if (s[8]) begin
				s = bcd_step({1'b0, q.sec[6:0]}, `RTCACC_MINSEC_LAST, 8'h00);
				n.sec = {q.sec[7], s[6:0]};
				if (s[8]) begin
					s = bcd_step({1'b0, q.min[6:0]}, `RTCACC_MINSEC_LAST, 8'h00);
					n.min = {q.min[7], s[6:0]};
					if (s[8] && view) begin
						n.ehours = bcd6_inc(q.ehours);
					end else if (s[8]) begin
						if (twelve) begin
							h12 = q.hour[4:0];
							if (h12 == 5'h11) begin
								n.hour = {2'b00, ~q.hour[5], 5'h12};
								day_c = q.hour[5];
							end else if (h12 >= 5'h12) begin
								n.hour = {2'b00, q.hour[5], 5'h01};
							end else begin
								s = bcd_step({3'b000, h12}, `RTCACC_HOUR12_LAST, 8'h01);
								n.hour = {2'b00, q.hour[5], s[4:0]};
							end
						end else begin
							s = bcd_step({2'b00, q.hour[5:0]}, `RTCACC_HOUR24_LAST, 8'h00);
							n.hour = {2'b00, s[5:0]};
							day_c = s[8];
						end
						if (day_c) begin
							s = bcd_step({2'b00, q.day[5:0]}, month_last(q.mon, q.year), 8'h01);
							n.day = {2'b00, s[5:0]};
							n.wday = 8'(bcd_step(q.wday, `RTCACC_DOW_LAST, 8'h00));
							if (s[8]) begin
								s = bcd_step(q.mon, `RTCACC_MONTH_LAST, 8'h01);
								n.mon = s[7:0];
								if (s[8]) begin
									n.year = 8'(bcd_step(q.year, `RTCACC_YEAR_LAST, 8'h00));
								end
							end
						end
					end
				end
			end
		end

		// Host writes win over the same-cycle count step
		if (req_i.wr && !req_i.ptr_load) begin
			case (q.ptr)
				`RTCACC_HUNDREDTHS_COUNT: n.hund = wval;
				`RTCACC_SECONDS_COUNT: n.sec = wval;
				`RTCACC_MINUTES_COUNT: n.min = wval;
				`RTCACC_HOURS_COUNT: begin
					if (view) n.ehours[7:0] = wval;
					else n.hour = wval;
				end
				`RTCACC_DAY_OF_MONTH_COUNT: begin
					if (view) n.ehours[15:8] = wval;
					else n.day = wval;
				end
				`RTCACC_DAY_OF_WEEK_COUNT: begin
					if (view) n.ehours[23:16] = wval;
					else n.wday = wval;
				end
				`RTCACC_MONTH_COUNT: begin
					if (!view) n.mon = wval;
				end
				`RTCACC_YEAR_COUNT: begin
					if (!view) n.year = wval;
				end
				`RTCACC_FUNCTION_CONTROL: n.func = wval;
				default: begin
				end
			endcase
		end

		// Read capture and pointer; the engine paces bytes at bus rate
		if (req_i.rd && !req_i.ptr_load) begin
			n.rdata = rval;
			n.rd_mem = is_alarm(q.ptr);
		end
		if (req_i.ptr_load) begin
			n.ptr = req_i.data;
		end else if (req_i.wr || req_i.rd) begin
			if (q.ptr >= `RTCACC_PTR_LAST) begin
				n.ptr = `RTCACC_PTR_FIRST;
			end else begin
				n.ptr = q.ptr + 8'h01;
			end
		end

		// Registered alarm comparison, calendar view only
		n.alm1 = !view
			&& (!en[`RTCACC_EN_A1_SEC] || (q.sec[6:0] == alm[0][6:0]))
			&& (!en[`RTCACC_EN_A1_MIN] || (q.min[6:0] == alm[1][6:0]))
			&& (!en[`RTCACC_EN_A1_HOUR] || (q.hour[5:0] == alm[2][5:0]))
			&& (!en[`RTCACC_EN_A1_DAY] || (q.day[5:0] == alm[3][5:0]))
			&& (!en[`RTCACC_EN_A1_MON] || (q.mon[4:0] == alm[4][4:0]));
		n.alm2 = !view
			&& (!en[`RTCACC_EN_A2_MIN] || (q.min[6:0] == alm[5][6:0]))
			&& (!en[`RTCACC_EN_A2_HOUR] || (q.hour[5:0] == alm[6][5:0]))
			&& (!en[`RTCACC_EN_A2_DOW] || (q.wday[2:0] == alm[7][2:0]));
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.day <= `RTCACC_RST_DAY;
			q.mon <= `RTCACC_RST_MONTH;
			q.frz <= FRZ_RUN;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data_o = q.rd_mem ? (mem_rd & 8'hff) : q.rdata;
	assign ptr_o = q.ptr;
	assign frozen_o = (q.frz == FRZ_HOLD);
	assign clock_view_select_o = view;
	assign alarm1_match_o = q.alm1;
	assign alarm2_match_o = q.alm2;

endmodule // rtcacc_top

// ---- tb/rtcacc_asserts.sv ----
`timescale 1ns/10ps

module rtcacc_asserts
	import rtcacc_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic osc_tick_i,
	input wire logic xfer_active_i,
	input wire rtcacc_req_s req_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [7:0] ptr_o,
	input wire logic frozen_o,
	input wire logic clock_view_select_o,
	input wire logic alarm1_match_o,
	input wire logic alarm2_match_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// A data byte that moves the pointer; a pointer load takes priority
	logic acc;
	assign acc = (req_i.rd | req_i.wr) & ~req_i.ptr_load;

	// ----------------------------------------------------------------
	// Pointer
	// ----------------------------------------------------------------
	a_ptr_step: assert property (acc && ptr_o < 8'h2f |=> ptr_o == $past(ptr_o) + 8'h01)
		else $error("pointer did not step by one");
	a_ptr_wrap: assert property (acc && ptr_o >= 8'h2f |=> ptr_o == 8'h00)
		else $error("pointer did not wrap to zero");
	a_ptr_load: assert property (req_i.ptr_load |=> ptr_o == $past(req_i.data))
		else $error("pointer load lost");
	a_ptr_idle: assert property (!req_i.ptr_load && !acc |=> $stable(ptr_o))
		else $error("pointer moved without a byte");

	// ----------------------------------------------------------------
	// Freeze, read data, view
	// ----------------------------------------------------------------
	a_freeze_rd: assert property (acc && req_i.rd && ptr_o < 8'h08 && xfer_active_i |=> frozen_o)
		else $error("time read did not freeze");
	a_freeze_hold: assert property (frozen_o && xfer_active_i |=> frozen_o)
		else $error("freeze dropped inside transfer");
	a_freeze_end: assert property (!xfer_active_i |=> !frozen_o)
		else $error("freeze outlived transfer");
	a_rdata_hold: assert property (!req_i.rd |=> $stable(rd_data_o))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (acc && req_i.rd && ptr_o > 8'h10 && ptr_o != 8'h28 |=> rd_data_o == 8'h00)
		else $error("unmapped location read nonzero");
	a_view_write: assert property (acc && req_i.wr && ptr_o == 8'h28
		|=> clock_view_select_o == $past(req_i.data[4]))
		else $error("view select not written");
	a_alarm_view: assert property (clock_view_select_o |=> !alarm1_match_o && !alarm2_match_o)
		else $error("alarm active in elapsed view");

	c_wrap: cover property (acc && ptr_o == 8'h2f);
	c_frozen: cover property ($rose(frozen_o));
	c_alarm: cover property ($fell(alarm1_match_o));
endmodule // rtcacc_asserts

bind rtcacc_top rtcacc_asserts rtcacc_asserts_inst (.clk_i(clk_i), .srst_i(srst_i), .osc_tick_i(osc_tick_i),
	.xfer_active_i(xfer_active_i), .req_i(req_i), .rd_data_o(rd_data_o), .ptr_o(ptr_o), .frozen_o(frozen_o),
	.clock_view_select_o(clock_view_select_o), .alarm1_match_o(alarm1_match_o), .alarm2_match_o(alarm2_match_o));

// ---- tb/rtcacc_host.sv ----
`timescale 1ns/10ps

module rtcacc_host
	import rtcacc_pkg::*;
#(
	parameter int BYTE_CYC = 450
) (
	input wire logic clk_i,
	output rtcacc_req_s req_o,
	output logic xfer_o
);
	initial begin
		req_o = '0;
		xfer_o = 1'b0;
	end

	// Kind 1 pointer load, 2 write, 3 read
	task automatic op(input int kind, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{ptr_load: kind == 1, wr: kind == 2, rd: kind == 3, data: d};
		@(posedge clk_i);
		// Released data lines must not keep showing the last byte
		req_o <= '{ptr_load: 1'b0, wr: 1'b0, rd: 1'b0, data: ~d};
		// Nine bit times at 400 kbit/s per byte
		repeat (BYTE_CYC) @(posedge clk_i);
	endtask

	task automatic frame(input logic on);
		@(posedge clk_i);
		xfer_o <= on;
	endtask
endmodule // rtcacc_host

// ---- tb/rtcacc_top_tb.sv ----
`timescale 1ns/10ps

module rtcacc_top_tb
	import rtcacc_pkg::*;
;
	logic clk_i;
	logic srst_i;
	logic osc_tick_i;
	logic xfer_active_i;
	rtcacc_req_s req_i;
	logic [7:0] rd_data_o;
	logic [7:0] ptr_o;
	logic frozen_o;
	logic clock_view_select_o;
	logic alarm1_match_o;
	logic alarm2_match_o;
	int errors = 0;
	int n_tests = 0;
	logic [7:0] exp_q[$];
	logic rd_seen = 1'b0;
	logic [31:0] seed = 32'hb245;
	logic [7:0] wv [9];
	logic [7:0] msk [9] = '{8'h7f, 8'h7f, 8'h3f, 8'h3f, 8'h1f, 8'h7f, 8'h3f, 8'h07, 8'hff};

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	rtcacc_top rtcacc_top_inst (.clk_i(clk_i), .srst_i(srst_i), .osc_tick_i(osc_tick_i),
		.xfer_active_i(xfer_active_i), .req_i(req_i), .rd_data_o(rd_data_o), .ptr_o(ptr_o), .frozen_o(frozen_o),
		.clock_view_select_o(clock_view_select_o), .alarm1_match_o(alarm1_match_o), .alarm2_match_o(alarm2_match_o));
	rtcacc_host rtcacc_host_inst (.clk_i(clk_i), .req_o(req_i), .xfer_o(xfer_active_i));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_exp(input logic [7:0] e);
		exp_q.push_back(e);
		// The data lines are a don't-care on a read, so they carry noise
		seed = lfsr(seed);
		rtcacc_host_inst.op(3, seed[7:0]);
	endtask

	task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
		rtcacc_host_inst.op(1, a);
		rtcacc_host_inst.op(2, d);
	endtask

	task automatic rd_at(input logic [7:0] a, input logic [7:0] e);
		rtcacc_host_inst.op(1, a);
		rd_exp(e);
	endtask

	task automatic tick_for(input int n);
		@(posedge clk_i);
		osc_tick_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		osc_tick_i <= 1'b0;
	endtask

	task automatic finish_test();
		$display("Checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Read data lands one cycle after the read is taken
	always @(posedge clk_i) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("Error read data expected none seen %h", rd_data_o);
			end else begin
				check("read data", exp_q.pop_front(), rd_data_o);
			end
		end
		rd_seen = req_i.rd === 1'b1;
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		errors++;
		$display("Error watchdog expected done seen timeout");
		finish_test();
	end

	initial begin
		srst_i = 1'b1;
		osc_tick_i = 1'b0;
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		rtcacc_host_inst.frame(1);
		rtcacc_host_inst.op(1, 8'h00);
		for (int i = 0; i < 17; i++) rd_exp((i == 4 || i == 6) ? 8'h01 : 8'h00);
		rtcacc_host_inst.frame(0);
		check("alarm1", 8'h01, {7'h00, alarm1_match_o});
		$display("Test reset contents done");
		// Random alarm bytes: unimplemented bits must read back as zero
		rtcacc_host_inst.frame(1);
		rtcacc_host_inst.op(1, 8'h08);
		for (int i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			wv[i] = seed[7:0];
			rtcacc_host_inst.op(2, wv[i]);
		end
		rtcacc_host_inst.op(1, 8'h08);
		for (int i = 0; i < 9; i++) rd_exp(wv[i] & msk[i]);
		wr_at(8'h20, seed[15:8]);
		rd_at(8'h20, 8'h00);
		wr_at(8'h00, 8'h37);
		rd_at(8'h2f, 8'h00);
		rd_exp(8'h37);
		check("pointer", 8'h01, ptr_o);
		$display("Test masks and wrap done");
		wr_at(8'h28, 8'h10);
		check("view", 8'h01, {7'h00, clock_view_select_o});
		check("alarms", 8'h00, {6'h00, alarm2_match_o, alarm1_match_o});
		rd_at(8'h06, 8'h00);
		wr_at(8'h28, 8'h00);
		rd_at(8'h06, 8'h01);
		rtcacc_host_inst.frame(0);
		$display("Test view select done");
		// Second reset clears the divider so the tick count is exact
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		rtcacc_host_inst.frame(1);
		wr_at(8'h28, 8'h20);
		wr_at(8'h00, 8'h99);
		rtcacc_host_inst.op(2, 8'h59);
		rtcacc_host_inst.op(2, 8'h59);
		rtcacc_host_inst.op(2, 8'h12);
		rtcacc_host_inst.frame(0);
		tick_for(330);
		repeat (10) @(posedge clk_i);
		rtcacc_host_inst.frame(1);
		rd_at(8'h00, 8'h00);
		rd_exp(8'h00);
		rd_exp(8'h00);
		rd_exp(8'h01);
		rtcacc_host_inst.frame(0);
		$display("Test counting done");
		rtcacc_host_inst.frame(1);
		rd_at(8'h00, 8'h00);
		check("frozen", 8'h01, {7'h00, frozen_o});
		tick_for(700);
		rd_at(8'h00, 8'h00);
		rtcacc_host_inst.frame(0);
		repeat (10) @(posedge clk_i);
		check("frozen", 8'h00, {7'h00, frozen_o});
		rtcacc_host_inst.frame(1);
		rd_at(8'h00, 8'h02);
		wr_at(8'h08, 8'h30);
		wr_at(8'h10, 8'h01);
		// Only the first alarm's second field is enabled and misses; the second alarm has none
		check("alarms", 8'h02, {6'h00, alarm2_match_o, alarm1_match_o});
		wr_at(8'h08, 8'h00);
		wr_at(8'h0d, 8'h05);
		wr_at(8'h10, 8'h21);
		check("alarms", 8'h01, {6'h00, alarm2_match_o, alarm1_match_o});
		rtcacc_host_inst.frame(0);
		$display("Test freeze and alarms done");
		// Elapsed view: a minute carry must step the six-digit hour count
		rtcacc_host_inst.frame(1);
		wr_at(8'h28, 8'h10);
		wr_at(8'h00, 8'h99);
		rtcacc_host_inst.op(2, 8'h59);
		rtcacc_host_inst.op(2, 8'h59);
		rtcacc_host_inst.op(2, 8'h99);
		rtcacc_host_inst.frame(0);
		tick_for(330);
		repeat (10) @(posedge clk_i);
		rtcacc_host_inst.frame(1);
		rd_at(8'h03, 8'h00);
		rd_exp(8'h01);
		rd_exp(8'h00);
		rtcacc_host_inst.frame(0);
		$display("Test elapsed view done");
		repeat (3) @(posedge clk_i);
		check("pending reads", 8'h00, 8'(exp_q.size()));
		finish_test();
	end
endmodule // rtcacc_top_tb
